// file: core/nfhc_consts.svh
// Offsets, command codes and timing counts of the NOR flash host controller
`ifndef NFHC_CONSTS_SVH
`define NFHC_CONSTS_SVH
`define NFHC_OFF_CTRL 12'h000
`define NFHC_OFF_ADDR 12'h004
`define NFHC_OFF_DATA 12'h008
`define NFHC_OFF_STAT 12'h00c
`define NFHC_OFF_RDAT 12'h010
`define NFHC_CTRL_GO 0
`define NFHC_CTRL_OP_LSB 1
`define NFHC_CTRL_BYTE 4
`define NFHC_STAT_BUSY 0
`define NFHC_STAT_ERR 1
`define NFHC_STAT_RB 2
`define NFHC_UNLOCK_A1 20'h00555
`define NFHC_UNLOCK_D1 16'h00aa
`define NFHC_UNLOCK_A2 20'h002aa
`define NFHC_UNLOCK_D2 16'h0055
`define NFHC_CMD_RESET 16'h00f0
`define NFHC_CMD_IDENT 16'h0090
`define NFHC_CMD_PROG 16'h00a0
`define NFHC_CMD_BYPASS 16'h0020
`define NFHC_CMD_BYP_EXIT1 16'h0090
`define NFHC_CMD_BYP_EXIT2 16'h0000
`define NFHC_CMD_SER_ENTER 16'h0088
`define NFHC_CMD_SER_EXIT 16'h0000
`define NFHC_STROBE_NS 100
`define NFHC_STROBE_CYC ((`NFHC_STROBE_NS + 24) / 25)
`define NFHC_POLL_LIMIT 24'hffffff
`endif

// file: core/nfhc_pkg.sv
// Types of the NOR flash host controller
package nfhc_pkg;
    typedef enum logic [2:0] {
        NFHC_OP_READ = 3'h0,
        NFHC_OP_RESET = 3'h1,
        NFHC_OP_IDENT = 3'h2,
        NFHC_OP_PROG = 3'h3,
        NFHC_OP_BYP_ENTER = 3'h4,
        NFHC_OP_BYP_PROG = 3'h5,
        NFHC_OP_BYP_EXIT = 3'h6,
        NFHC_OP_SER = 3'h7
    } nfhc_op_e;
    typedef enum logic [2:0] {
        NFHC_IDLE = 3'b000,
        NFHC_SETUP = 3'b001,
        NFHC_STROBE = 3'b011,
        NFHC_HOLD = 3'b010,
        NFHC_POLL = 3'b110,
        NFHC_DONE = 3'b111
    } nfhc_state_e;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic byte_n;
    } nfhc_ctl_s;
    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] data;
    } nfhc_cyc_s;
endpackage

// file: core/nfhc_host.sv
// NOR flash host controller: APB registers in, flash strobe sequences out
`include "nfhc_consts.svh"
module nfhc_host (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [19:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic flash_byte_n,
    input wire logic ready_busy_n
);
    nfhc_pkg::nfhc_state_e state_reg, state_next;
    nfhc_pkg::nfhc_ctl_s ctl_reg;
    logic [19:0] addr_reg;
    logic [15:0] data_reg;
    logic [15:0] rdat_reg;
    logic [2:0] op_reg;
    logic [2:0] step_reg;
    logic [7:0] tcnt_reg;
    logic [23:0] poll_reg;
    logic err_reg;
    logic byte_reg;
    logic ser_reg;
    logic byp_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    wire busy = state_reg != nfhc_pkg::NFHC_IDLE;
    wire apb_setup = psel && !penable;
    wire wr_ctrl = apb_setup && pwrite && paddr == `NFHC_OFF_CTRL;
    wire go = wr_ctrl && pwdata[`NFHC_CTRL_GO] && !busy;
    wire [2:0] go_op = pwdata[`NFHC_CTRL_OP_LSB +: 3];
    wire addr_hit = paddr == `NFHC_OFF_CTRL || paddr == `NFHC_OFF_ADDR || paddr == `NFHC_OFF_DATA ||
        paddr == `NFHC_OFF_STAT || paddr == `NFHC_OFF_RDAT;
    // Bypass is refused inside the serial sector; the request flags an error instead
    wire op_illegal = (go_op == 3'h4 && ser_reg) ||
        ((go_op == 3'h5 || go_op == 3'h6) && !byp_reg) ||
        (byp_reg && go_op != 3'h0 && go_op != 3'h5 && go_op != 3'h6);
    wire [31:0] rd_mux = paddr == `NFHC_OFF_CTRL ? {27'h0, byte_reg, op_reg, 1'b0} :
        paddr == `NFHC_OFF_ADDR ? {12'h0, addr_reg} :
        paddr == `NFHC_OFF_DATA ? {16'h0, data_reg} :
        paddr == `NFHC_OFF_STAT ? {27'h0, byp_reg, ser_reg, !ready_busy_n, err_reg, busy} :
        paddr == `NFHC_OFF_RDAT ? {16'h0, rdat_reg} : 32'h0;

    // Number of strobed cycles in each operation, reads included
    wire [2:0] nsteps = op_reg == 3'h0 ? 3'h1 : op_reg == 3'h1 ? 3'h1 : op_reg == 3'h2 ? 3'h3 :
        op_reg == 3'h3 ? 3'h4 : op_reg == 3'h4 ? 3'h3 : op_reg == 3'h5 ? 3'h2 : op_reg == 3'h6 ? 3'h2 :
        (ser_reg ? 3'h4 : 3'h3);
    wire last_step = step_reg == nsteps - 3'h1;
    wire is_read = op_reg == 3'h0;
    wire unlock1 = step_reg == 3'h0;
    wire unlock2 = step_reg == 3'h1;
    // Sequence table: unlocks, then the command, then for programs the target address and data; reset and bypass-mode cycles have no unlocks
    wire [15:0] cmd_code = op_reg == 3'h1 ? `NFHC_CMD_RESET : op_reg == 3'h2 ? `NFHC_CMD_IDENT :
        op_reg == 3'h3 ? `NFHC_CMD_PROG : op_reg == 3'h4 ? `NFHC_CMD_BYPASS :
        op_reg == 3'h7 ? (ser_reg ? `NFHC_CMD_SER_EXIT : `NFHC_CMD_SER_ENTER) : 16'h0;
    wire two_step = op_reg == 3'h5 || op_reg == 3'h6;
    wire [15:0] byp_code = op_reg == 3'h5 ? `NFHC_CMD_PROG :
        (unlock1 ? `NFHC_CMD_BYP_EXIT1 : `NFHC_CMD_BYP_EXIT2);
    wire final_target = (op_reg == 3'h3 && step_reg == 3'h3) || (op_reg == 3'h5 && step_reg == 3'h1);
    wire ser_exit4 = op_reg == 3'h7 && ser_reg && step_reg == 3'h3;
    nfhc_pkg::nfhc_cyc_s cyc;
    assign cyc.addr = (is_read || final_target) ? addr_reg :
        (two_step || op_reg == 3'h1) ? addr_reg :
        unlock1 ? `NFHC_UNLOCK_A1 : unlock2 ? `NFHC_UNLOCK_A2 : `NFHC_UNLOCK_A1;
    assign cyc.data = final_target ? data_reg : two_step ? byp_code : op_reg == 3'h1 ? cmd_code :
        ser_exit4 ? `NFHC_CMD_SER_EXIT :
        unlock1 ? `NFHC_UNLOCK_D1 : unlock2 ? `NFHC_UNLOCK_D2 : cmd_code;
    wire strobe_done = tcnt_reg == 8'(`NFHC_STROBE_CYC - 1);
    // Programming completion is watched on ready/busy with a bounded poll
    wire prog_op = op_reg == 3'h3 || op_reg == 3'h5;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            nfhc_pkg::NFHC_IDLE: if (go && !op_illegal) state_next = nfhc_pkg::NFHC_SETUP;
            nfhc_pkg::NFHC_SETUP: if (strobe_done) state_next = nfhc_pkg::NFHC_STROBE;
            nfhc_pkg::NFHC_STROBE: if (strobe_done) state_next = nfhc_pkg::NFHC_HOLD;
            nfhc_pkg::NFHC_HOLD: if (strobe_done) begin
                if (!last_step) state_next = nfhc_pkg::NFHC_SETUP;
                else if (prog_op) state_next = nfhc_pkg::NFHC_POLL;
                else state_next = nfhc_pkg::NFHC_DONE;
            end
            // Nothing is written while the device programs; new commands are ignored
            nfhc_pkg::NFHC_POLL: if ((ready_busy_n && tcnt_reg == 8'hff) || poll_reg == `NFHC_POLL_LIMIT) begin
                state_next = nfhc_pkg::NFHC_DONE;
            end
            nfhc_pkg::NFHC_DONE: state_next = nfhc_pkg::NFHC_IDLE;
            default: state_next = nfhc_pkg::NFHC_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) state_reg <= nfhc_pkg::NFHC_IDLE;
        else state_reg <= state_next;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) tcnt_reg <= 8'h00;
        else if (state_reg != state_next) tcnt_reg <= 8'h00;
        else if (tcnt_reg != 8'hff) tcnt_reg <= tcnt_reg + 8'h01;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) poll_reg <= 24'h0;
        else if (state_reg != nfhc_pkg::NFHC_POLL) poll_reg <= 24'h0;
        else poll_reg <= poll_reg + 24'h1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) step_reg <= 3'h0;
        else if (state_reg == nfhc_pkg::NFHC_IDLE) step_reg <= 3'h0;
        else if (state_reg == nfhc_pkg::NFHC_HOLD && strobe_done) step_reg <= step_reg + 3'h1;
    end

    // Strobes: select and write low with output high form a write; output low only for reads
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, byte_n: 1'b1};
        end else begin
            ctl_reg.byte_n <= !byte_reg;
            ctl_reg.ce_n <= !(state_next == nfhc_pkg::NFHC_STROBE);
            ctl_reg.we_n <= !(state_next == nfhc_pkg::NFHC_STROBE && !is_read);
            ctl_reg.oe_n <= !(state_next == nfhc_pkg::NFHC_STROBE && is_read);
        end
    end

    // Address and data settle three cycles before the strobes move, one cycle into the four-cycle setup phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_addr <= 20'h0;
            flash_dq_out <= 16'h0;
            flash_dq_oe_n <= 1'b1;
        end else begin
            flash_addr <= cyc.addr;
            flash_dq_out <= cyc.data;
            flash_dq_oe_n <= !(busy && !is_read && state_reg != nfhc_pkg::NFHC_POLL &&
                state_reg != nfhc_pkg::NFHC_DONE);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= 3'h0;
            byte_reg <= 1'b0;
            addr_reg <= 20'h0;
            data_reg <= 16'h0;
        end else begin
            if (go) op_reg <= go_op;
            if (wr_ctrl && !busy) byte_reg <= pwdata[`NFHC_CTRL_BYTE];
            if (apb_setup && pwrite && paddr == `NFHC_OFF_ADDR && !busy) addr_reg <= pwdata[19:0];
            if (apb_setup && pwrite && paddr == `NFHC_OFF_DATA && !busy) data_reg <= pwdata[15:0];
        end
    end

    // Mode tracking mirrors the device: bypass and serial sector end as documented
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ser_reg <= 1'b0;
            byp_reg <= 1'b0;
            err_reg <= 1'b0;
            rdat_reg <= 16'h0;
        end else begin
            if (state_reg == nfhc_pkg::NFHC_STROBE && is_read && strobe_done) rdat_reg <= flash_dq_in;
            if (state_reg == nfhc_pkg::NFHC_DONE) begin
                if (op_reg == 3'h7) ser_reg <= !ser_reg;
                if (op_reg == 3'h4) byp_reg <= 1'b1;
                if (op_reg == 3'h6) byp_reg <= 1'b0;
                // Reset after a timeout or from query mode restores array reads
                if (op_reg == 3'h1) byp_reg <= 1'b0;
            end
            if (go && op_illegal) err_reg <= 1'b1;
            else if (state_reg == nfhc_pkg::NFHC_POLL && poll_reg == `NFHC_POLL_LIMIT) err_reg <= 1'b1;
            else if (go) err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup && !addr_hit;
            prdata_reg <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign flash_ce_n = ctl_reg.ce_n;
    assign flash_we_n = ctl_reg.we_n;
    assign flash_oe_n = ctl_reg.oe_n;
    assign flash_byte_n = ctl_reg.byte_n;

    sequence write_strobe_s;
        !flash_we_n && !flash_ce_n;
    endsequence
    wr_qual_a: assert property (@(posedge clock) disable iff (!rst_n)
        !flash_we_n |-> !flash_ce_n && flash_oe_n) else $error("write strobe without select");
    oe_excl_a: assert property (@(posedge clock) disable iff (!rst_n)
        !flash_oe_n |-> flash_we_n) else $error("output and write low together");
    we_width_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(flash_we_n) |-> write_strobe_s [*4]) else $error("write strobe too short");
    data_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
        write_strobe_s |-> $stable(flash_dq_out) && !flash_dq_oe_n) else $error("data moved under strobe");
    byp_block_a: assert property (@(posedge clock) disable iff (!rst_n)
        (go && go_op == 3'h4 && ser_reg) |=> state_reg == nfhc_pkg::NFHC_IDLE && err_reg)
        else $error("bypass entered in serial sector");
    busy_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == nfhc_pkg::NFHC_POLL |-> flash_we_n) else $error("write during programming");
    pready_a: assert property (@(posedge clock) disable iff (!rst_n)
        apb_setup |=> pready) else $error("apb answer late");
    unlock_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h3 && step_reg == 3'h0) |->
        flash_dq_out == `NFHC_UNLOCK_D1) else $error("first unlock data wrong");

    sequence read_strobe_s;
        !flash_oe_n && !flash_ce_n;
    endsequence
    sequence strobe_gap_s;
        flash_ce_n [*8];
    endsequence
    // Every pulse is followed by a full hold and setup, so the device sees distinct cycles
    rd_width_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(flash_oe_n) |-> read_strobe_s [*4]) else $error("read strobe too short");
    strobe_gap_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(flash_ce_n) |-> strobe_gap_s) else $error("select gap too short");
    addr_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
        write_strobe_s |-> $stable(flash_addr)) else $error("address moved under strobe");
    unlock_two_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && step_reg == 3'h1 && !is_read && !two_step && op_reg != 3'h1) |->
        flash_addr == `NFHC_UNLOCK_A2 && flash_dq_out == `NFHC_UNLOCK_D2) else $error("second unlock wrong");
    prog_setup_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h3 && step_reg == 3'h2) |->
        flash_addr == `NFHC_UNLOCK_A1 && flash_dq_out == `NFHC_CMD_PROG) else $error("program setup write wrong");
    reset_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h1) |->
        flash_dq_out == `NFHC_CMD_RESET) else $error("reset command wrong");
    ident_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h2 && step_reg == 3'h2) |->
        flash_dq_out == `NFHC_CMD_IDENT) else $error("query command wrong");
    byp_enter_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h4 && step_reg == 3'h2) |->
        flash_dq_out == `NFHC_CMD_BYPASS) else $error("bypass entry command wrong");
    byp_prog_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h5 && step_reg == 3'h0) |->
        flash_dq_out == `NFHC_CMD_PROG) else $error("bypass program command wrong");
    byp_exit_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h6) |->
        flash_dq_out == (step_reg == 3'h0 ? `NFHC_CMD_BYP_EXIT1 : `NFHC_CMD_BYP_EXIT2)) else $error("bypass exit wrong");
    ser_enter_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h7 && !ser_reg && step_reg == 3'h2) |->
        flash_dq_out == `NFHC_CMD_SER_ENTER) else $error("serial entry command wrong");
    ser_exit_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == nfhc_pkg::NFHC_STROBE && op_reg == 3'h7 && ser_reg && step_reg == 3'h3) |->
        flash_dq_out == `NFHC_CMD_SER_EXIT) else $error("serial exit command wrong");
    poll_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == nfhc_pkg::NFHC_POLL |-> flash_ce_n && flash_oe_n) else $error("strobe while programming");
    slverr_a: assert property (@(posedge clock) disable iff (!rst_n)
        (apb_setup && !addr_hit) |=> pslverr) else $error("unmapped access not flagged");
endmodule // nfhc_host

// file: verif/nfhc_flash_model.sv
// Behavioural flash device answering the host controller's strobes
module nfhc_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h005a, // Arbitrary value
    parameter int PROG_NS = 8000
) (
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic byte_n,
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_host,
    input wire logic dq_host_oe_n,
    output logic [15:0] dq_in,
    output logic ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];
    logic [15:0] serial_number_value [0:7];
    logic [19:0] a_lat;
    logic [15:0] last;
    logic [7:0] d;
    logic ident, bypass, ser, lockout;
    int step;
    wire wr = !ce_n && !we_n && oe_n;
    wire rd = !ce_n && !oe_n;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
        for (int i = 0; i < 8; i++) serial_number_value[i] = 16'h5e00 + 16'(i);
        {ident, bypass, ser, lockout, step, last} = '0;
        ready_busy_n = 1'b1;
    end
    always @(posedge wr) a_lat = addr;
    // Guard with case equality so the startup edge out of unknown strobes is no write
    always @(negedge wr) begin
        d = dq_host[7:0];
        // Below the supply lockout level every write is lost and the command state is cleared
        if (lockout) {ident, bypass, ser, step} = '0;
        else if (ready_busy_n === 1'b1 && dq_host_oe_n === 1'b0) begin
            if (step == 3 || step == 4) begin
                mem[a_lat[7:0]] = mem[a_lat[7:0]] & dq_host;
                ready_busy_n = 1'b0;
                step = 0;
            end else if (d == 8'hf0 && !bypass) begin
                {ident, step} = '0;
            end else if (bypass) begin
                if (step == 0 && d == 8'ha0) step = 4;
                else if (step == 0 && d == 8'h90) step = 5;
                else begin
                    if (step == 5 && d == 8'h00) bypass = 1'b0;
                    step = 0;
                end
            end else if (step == 0 && a_lat[10:0] == 11'h555 && d == 8'haa) step = 1;
            else if (step == 1 && a_lat[10:0] == 11'h2aa && d == 8'h55) step = 2;
            else if (step == 2 && ser && d == 8'h00) step = 6;
            else if (step == 2 && d == 8'ha0) step = 3;
            else if (step == 2 && d == 8'h90) begin
                if (ser) step = 6;
                else {ident, step} = {1'b1, 32'd0};
            end else begin
                if (step == 2 && d == 8'h88) ser = 1'b1;
                if (step == 2 && d == 8'h20 && !ser) bypass = 1'b1;
                if (step == 6 && d == 8'h00) ser = 1'b0;
                step = 0;
            end
        end
    end
    // Program completes to array read after a fixed time
    always @(negedge ready_busy_n) begin
        #PROG_NS;
        ready_busy_n = 1'b1;
    end
    // A released bus shows the inverse of the last data, never a stale copy
    always @* begin
        if (rd) begin
            if (ident) dq_in = addr[7:0] == 8'h00 ? MAKER_CODE : addr[7:0] == 8'h01 ? PART_CODE : 16'h0000;
            else if (ser) dq_in = serial_number_value[addr[2:0]];
            else dq_in = mem[addr[7:0]];
            last = dq_in;
        end else if (dq_host_oe_n === 1'b0) dq_in = dq_host;
        else dq_in = ~last;
    end
endmodule // nfhc_flash_model

// file: verif/nfhc_host_tb.sv
// Self-checking testbench of the NOR flash host controller
`include "nfhc_consts.svh"
module nfhc_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n, ready_busy_n;
    int fail_count, tests_run;
    nfhc_host nfhc_host_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .flash_byte_n(flash_byte_n), .ready_busy_n(ready_busy_n));
    nfhc_flash_model nfhc_flash_model_inst (.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
        .byte_n(flash_byte_n), .addr(flash_addr), .dq_host(flash_dq_out), .dq_host_oe_n(flash_dq_oe_n),
        .dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic close_out();
        $display("Checks run %0d, failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic timeout(input string name);
        fail_count++;
        $display("[FAIL] %s expected completion seen timeout", name);
        close_out();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) timeout("apb answer");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic op(input nfhc_pkg::nfhc_op_e o);
        int n;
        apb(1'b1, `NFHC_OFF_CTRL, {27'h0, 1'b0, o, 1'b1});
        n = 0;
        do begin
            apb(1'b0, `NFHC_OFF_STAT, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 3000);
        if (n >= 3000) timeout("operation busy");
    endtask
    task automatic flash_rd(input string name, input logic [19:0] a, input logic [15:0] exp);
        apb(1'b1, `NFHC_OFF_ADDR, {12'h0, a});
        op(nfhc_pkg::NFHC_OP_READ);
        apb(1'b0, `NFHC_OFF_RDAT, 32'h0);
        check(name, {16'h0, exp}, {16'h0, r[15:0]});
    endtask
    task automatic stat_bit(input string name, input int b, input logic exp);
        apb(1'b0, `NFHC_OFF_STAT, 32'h0);
        check(name, {31'h0, exp}, {31'h0, r[b]});
    endtask
    task automatic idle_and_unmapped();
        check("idle strobes", 32'hf, {28'h0, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n});
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, `NFHC_OFF_CTRL, 32'h10);
        check("byte select pin", 32'h0, {31'h0, flash_byte_n});
        apb(1'b0, `NFHC_OFF_CTRL, 32'h0);
        check("byte mode bit", 32'h10, r);
        apb(1'b1, `NFHC_OFF_CTRL, 32'h0);
    endtask
    task automatic lockout_ignored();
        nfhc_flash_model_inst.lockout <= 1'b1;
        apb(1'b1, `NFHC_OFF_ADDR, 32'h30);
        apb(1'b1, `NFHC_OFF_DATA, 32'h0000);
        op(nfhc_pkg::NFHC_OP_PROG);
        nfhc_flash_model_inst.lockout <= 1'b0;
        flash_rd("lockout word", 20'h30, 16'hffff);
    endtask
    task automatic program_and_clear_only();
        apb(1'b1, `NFHC_OFF_ADDR, 32'h10);
        apb(1'b1, `NFHC_OFF_DATA, 32'h1234);
        op(nfhc_pkg::NFHC_OP_PROG);
        flash_rd("programmed word", 20'h10, 16'h1234);
        apb(1'b1, `NFHC_OFF_DATA, 32'hffff);
        op(nfhc_pkg::NFHC_OP_PROG);
        flash_rd("bits stay cleared", 20'h10, 16'h1234);
    endtask
    task automatic query_then_reset();
        op(nfhc_pkg::NFHC_OP_IDENT);
        flash_rd("maker code", 20'h0, 16'h00a5);
        flash_rd("part code", 20'h1, 16'h005a);
        flash_rd("protect bit", 20'h2, 16'h0000);
        flash_rd("query persists", 20'h0, 16'h00a5);
        op(nfhc_pkg::NFHC_OP_RESET);
        flash_rd("array after reset", 20'h10, 16'h1234);
    endtask
    task automatic bypass_program();
        op(nfhc_pkg::NFHC_OP_BYP_ENTER);
        stat_bit("bypass on", 4, 1'b1);
        apb(1'b1, `NFHC_OFF_ADDR, 32'h20);
        apb(1'b1, `NFHC_OFF_DATA, 32'h00ff);
        op(nfhc_pkg::NFHC_OP_BYP_PROG);
        op(nfhc_pkg::NFHC_OP_BYP_EXIT);
        stat_bit("bypass off", 4, 1'b0);
        flash_rd("bypass word", 20'h20, 16'h00ff);
    endtask
    task automatic serial_sector();
        op(nfhc_pkg::NFHC_OP_SER);
        flash_rd("serial word", 20'h3, 16'h5e03);
        op(nfhc_pkg::NFHC_OP_BYP_ENTER);
        stat_bit("bypass refused", 1, 1'b1);
        op(nfhc_pkg::NFHC_OP_SER);
        flash_rd("array after exit", 20'h10, 16'h1234);
    endtask
    // Write strobe must never overlap the output strobe and must carry host-driven data
    always @(posedge clock) begin
        if (rst_n && !flash_we_n) begin
            tests_run++;
            if (flash_ce_n || !flash_oe_n || flash_dq_oe_n) begin
                fail_count++;
                $display("[FAIL] write strobes expected ce_n 0 oe_n 1 dq_oe_n 0 seen %b%b%b",
                    flash_ce_n, flash_oe_n, flash_dq_oe_n);
            end
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, fail_count, tests_run} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        idle_and_unmapped();
        program_and_clear_only();
        lockout_ignored();
        query_then_reset();
        bypass_program();
        serial_sector();
        close_out();
    end
endmodule // nfhc_host_tb
